// file: tdmssm_regs.svh
// Register offsets, field positions, reset values and timing counts of the slot mapper.
`ifndef TDMSSM_REGS_SVH
`define TDMSSM_REGS_SVH

// Register offsets.
`define TDMSSM_ADDR_TX_FORMAT   8'h0E
`define TDMSSM_ADDR_VSNS_CFG    8'h0F
`define TDMSSM_ADDR_ISNS_CFG    8'h10
`define TDMSSM_ADDR_PDM_CFG     8'h11
`define TDMSSM_ADDR_VBAT_CFG    8'h12
`define TDMSSM_ADDR_TEMP_CFG    8'h13
`define TDMSSM_ADDR_GAIN_CFG    8'h14
`define TDMSSM_ADDR_LIM_CFG     8'h15
`define TDMSSM_REG_COUNT        8

// Reset values.
`define TDMSSM_RST_TX_FORMAT    8'h13
`define TDMSSM_RST_VSNS_CFG     8'h02
`define TDMSSM_RST_ISNS_CFG     8'h00
`define TDMSSM_RST_PDM_CFG      8'h04
`define TDMSSM_RST_VBAT_CFG     8'h06
`define TDMSSM_RST_TEMP_CFG     8'h07
`define TDMSSM_RST_GAIN_CFG     8'h08
`define TDMSSM_RST_LIM_CFG      8'h14

// Field positions.
`define TDMSSM_TX_EN_BIT        6
`define TDMSSM_SLOT_MSB         5
`define TDMSSM_VBAT_LEN_BIT     7
`define TDMSSM_FILL_BIT         4
`define TDMSSM_LIMITER_ON_BIT   0
`define TDMSSM_ATK_ST_LSB       4
`define TDMSSM_ATK_RT_LSB       1

// Timing: base attack interval and system clock rate.
`define TDMSSM_ATK_BASE_NS      5000
`define TDMSSM_CLK_MHZ          50
`define TDMSSM_ATK_BASE_CYCLES  ((`TDMSSM_ATK_BASE_NS * `TDMSSM_CLK_MHZ) / 1000)

`endif

// file: tdmssm_pkg.sv
// Types shared by the slot mapper modules.
package tdmssm_pkg;
    typedef enum logic [2:0] {
        LNK_IDLE = 3'h1,
        LNK_SHIFT = 3'h2,
        LNK_DONE = 3'h4
    } tdmssm_link_state_t;
    typedef logic [15:0] tdmssm_word_t;
endpackage

// file: tdmssm_limiter.sv
// Limiter attack engine that builds up the gain-reduction value.
`timescale 1ns/1ps
`include "tdmssm_regs.svh"
module tdmssm_limiter #(
    parameter int BASE_CYCLES = `TDMSSM_ATK_BASE_CYCLES,
    parameter int GR_W        = 8
) (
    // Clock and reset.
    input  wire logic            clk,
    input  wire logic            sys_rst,
    // Settings.
    input  wire logic            limiterOn,
    input  wire logic [1:0]      attackStepSize,
    input  wire logic [2:0]      attackStepInterval,
    // Level detector.
    input  wire logic            overThreshold,
    // Gain reduction in quarter-dB units.
    output logic [GR_W-1:0]      gainReduction
);
    localparam int CNT_W = $clog2(BASE_CYCLES * 128 + 1);

    logic [CNT_W-1:0] tick_r;
    logic [GR_W:0]    sum;
    logic [GR_W-1:0]  step;
    logic [CNT_W-1:0] reload;

    // Refuse settings that the counter and the saturation logic cannot serve.
    if (BASE_CYCLES < 1 || GR_W < 4 || GR_W > 16) begin : g_badParams
        $error("tdmssm_limiter: unsupported parameters");
    end

    // Step in quarter-dB: 0.25, 0.5, 1 or 2 dB.
    assign step = GR_W'(1) << attackStepSize;
    // Reload gives a period of the base interval doubled once per code step.
    assign reload = (CNT_W'(BASE_CYCLES) << attackStepInterval) - CNT_W'(1);
    assign sum = {1'b0, gainReduction} + {1'b0, step};

    // Interval timer; held idle while the limiter is off.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tick_r <= '0;
        end else if (!limiterOn) begin
            tick_r <= '0;
        end else if (tick_r == '0) begin
            tick_r <= reload + CNT_W'(0);
        end else begin
            tick_r <= tick_r - CNT_W'(1);
        end
    end

    // Gain reduction grows by one step per interval while over threshold, saturating.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            gainReduction <= '0;
        end else if (!limiterOn) begin
            gainReduction <= '0;
        end else if (tick_r == '0 && overThreshold) begin
            gainReduction <= sum[GR_W] ? '1 : sum[GR_W-1:0];
        end
    end
endmodule

// file: tdmssm_top.sv
// Transmit slot mapper of the serial audio port with limiter attack settings.
`timescale 1ns/1ps
`include "tdmssm_regs.svh"

module tdmssm_top #(
    parameter int ATK_BASE_CYCLES = `TDMSSM_ATK_BASE_CYCLES,
    parameter int VBAT_W          = 12,
    parameter int SLOT_BITS       = 16
) (
    // System clock and reset.
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Register port.
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    output logic      [7:0]  regRdData_r,
    // Monitoring samples, system clock domain.
    input  wire logic [15:0] currentSenseData,
    input  wire logic [15:0] voltageSenseData,
    input  wire logic [15:0] decimatedData,
    input  wire logic [VBAT_W-1:0] supplyVoltage,
    input  wire logic [7:0]  temperature,
    input  wire logic        overThreshold,
    // Serial link, clocked by the host.
    input  wire logic        serial_bit_clock,
    input  wire logic        frameSync,
    output logic             serialOutLine_r,
    output logic             serialOutLineEn_r
);
    localparam int NSRC  = 6;
    localparam int BIT_W = $clog2(SLOT_BITS);
    localparam int POS_W = 6 + BIT_W;

    // Refuse widths that the slot and supply formatting logic cannot serve.
    if (VBAT_W < 8 || VBAT_W > 16 || SLOT_BITS < 16 || (SLOT_BITS & (SLOT_BITS - 1)) != 0) begin : g_badParams
        $error("tdmssm_top: unsupported parameters");
    end

    // ---- System domain: configuration registers ----
    logic [7:0] cfg_r [`TDMSSM_REG_COUNT];
    logic [2:0] regIdx;
    logic       regHit;
    logic [7:0] gainReduction;

    // Register values after reset, also the first snapshot on both sides of the crossing.
    localparam logic [7:0] CFG_RST [`TDMSSM_REG_COUNT] = '{
        `TDMSSM_RST_TX_FORMAT, `TDMSSM_RST_VSNS_CFG, `TDMSSM_RST_ISNS_CFG, `TDMSSM_RST_PDM_CFG,
        `TDMSSM_RST_VBAT_CFG, `TDMSSM_RST_TEMP_CFG, `TDMSSM_RST_GAIN_CFG, `TDMSSM_RST_LIM_CFG
    };

    // Decode the register offsets 0x0E..0x15 into a storage index.
    always_comb begin
        regHit = 1'b0;
        regIdx = 3'h0;
        if (regAddr >= `TDMSSM_ADDR_TX_FORMAT && regAddr <= `TDMSSM_ADDR_LIM_CFG) begin
            regHit = 1'b1;
            regIdx = 3'(regAddr - `TDMSSM_ADDR_TX_FORMAT);
        end else begin
            regHit = 1'b0;
        end
    end

    // Software writes; every field is read-write and resets to its documented value.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_r[0] <= `TDMSSM_RST_TX_FORMAT;
            cfg_r[1] <= `TDMSSM_RST_VSNS_CFG;
            cfg_r[2] <= `TDMSSM_RST_ISNS_CFG;
            cfg_r[3] <= `TDMSSM_RST_PDM_CFG;
            cfg_r[4] <= `TDMSSM_RST_VBAT_CFG;
            cfg_r[5] <= `TDMSSM_RST_TEMP_CFG;
            cfg_r[6] <= `TDMSSM_RST_GAIN_CFG;
            cfg_r[7] <= `TDMSSM_RST_LIM_CFG;
        end else if (regWrEn && regHit) begin
            cfg_r[regIdx] <= regWrData;
        end
    end

    // Read data is registered; unmapped offsets read as zero.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            regRdData_r <= 8'h00;
        end else if (regRdEn) begin
            regRdData_r <= regHit ? cfg_r[regIdx] : 8'h00;
        end
    end

    // Limiter attack engine steered by the limiter register.
    tdmssm_limiter #(
        .BASE_CYCLES (ATK_BASE_CYCLES),
        .GR_W        (8)
    ) u_limiter (
        .clk                (clk),
        .sys_rst            (sys_rst),
        .limiterOn          (cfg_r[7][`TDMSSM_LIMITER_ON_BIT]),
        .attackStepSize     (cfg_r[7][`TDMSSM_ATK_ST_LSB +: 2]),
        .attackStepInterval (cfg_r[7][`TDMSSM_ATK_RT_LSB +: 3]),
        .overThreshold      (overThreshold),
        .gainReduction      (gainReduction)
    );

    // Source words, MSB first; supply voltage formatted by its length bit.
    tdmssm_pkg::tdmssm_word_t srcWord [NSRC];
    logic [15:0] vbatWide;
    assign vbatWide   = 16'({supplyVoltage, {(16 - VBAT_W + 1){1'b0}}} >> 1);
    assign srcWord[0] = currentSenseData;
    assign srcWord[1] = voltageSenseData;
    assign srcWord[2] = decimatedData;
    assign srcWord[3] = cfg_r[4][`TDMSSM_VBAT_LEN_BIT] ? vbatWide : {vbatWide[15:8], 8'h00};
    assign srcWord[4] = {temperature, 8'h00};
    assign srcWord[5] = {gainReduction, 8'h00};

    // ---- Crossing: toggle handshake carrying one snapshot per frame ----
    logic       reqTgl_r;
    logic       reqS1_r;
    logic       reqS2_r;
    logic       ackTgl_r;
    logic [7:0] holdCfg_r  [`TDMSSM_REG_COUNT];
    tdmssm_pkg::tdmssm_word_t holdData_r [NSRC];

    // Request toggle from the link is brought into the system domain.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reqS1_r <= 1'b0;
            reqS2_r <= 1'b0;
        end else begin
            reqS1_r <= reqTgl_r;
            reqS2_r <= reqS1_r;
        end
    end

    // On a new request, capture settings and samples, then acknowledge.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ackTgl_r <= 1'b0;
            for (int i = 0; i < `TDMSSM_REG_COUNT; i++) begin
                holdCfg_r[i] <= CFG_RST[i];
            end
            for (int i = 0; i < NSRC; i++) begin
                holdData_r[i] <= 16'h0000;
            end
        end else if (reqS2_r != ackTgl_r) begin
            ackTgl_r <= reqS2_r;
            for (int i = 0; i < `TDMSSM_REG_COUNT; i++) begin
                holdCfg_r[i] <= cfg_r[i];
            end
            for (int i = 0; i < NSRC; i++) begin
                holdData_r[i] <= srcWord[i];
            end
        end
    end

    // ---- Link domain, clocked by the host bit clock ----
    logic lrstS1_r;
    logic linkRst;
    logic fsS1_r;
    logic fsS2_r;
    logic fsS3_r;
    logic ackS1_r;
    logic ackS2_r;
    logic fsRise;
    tdmssm_pkg::tdmssm_link_state_t linkState_r;
    logic [POS_W-1:0] bitPos_r;
    logic [7:0]       actCfg_r  [`TDMSSM_REG_COUNT];
    tdmssm_pkg::tdmssm_word_t actData_r [NSRC];

    // Reset is asserted at once and released on the bit clock.
    always_ff @(posedge serial_bit_clock or posedge sys_rst) begin
        if (sys_rst) begin
            lrstS1_r <= 1'b1;
            linkRst  <= 1'b1;
        end else begin
            lrstS1_r <= 1'b0;
            linkRst  <= lrstS1_r;
        end
    end

    // Frame sync pin and acknowledge pass two flip-flops before use.
    always_ff @(posedge serial_bit_clock or posedge linkRst) begin
        if (linkRst) begin
            fsS1_r  <= 1'b0;
            fsS2_r  <= 1'b0;
            fsS3_r  <= 1'b0;
            ackS1_r <= 1'b0;
            ackS2_r <= 1'b0;
        end else begin
            fsS1_r  <= frameSync;
            fsS2_r  <= fsS1_r;
            fsS3_r  <= fsS2_r;
            ackS1_r <= ackTgl_r;
            ackS2_r <= ackS1_r;
        end
    end

    assign fsRise = fsS2_r && !fsS3_r;

    // At frame start, adopt the last completed snapshot and ask for the next one.
    always_ff @(posedge serial_bit_clock or posedge linkRst) begin
        if (linkRst) begin
            reqTgl_r <= 1'b0;
            for (int i = 0; i < `TDMSSM_REG_COUNT; i++) begin
                actCfg_r[i] <= CFG_RST[i];
            end
            for (int i = 0; i < NSRC; i++) begin
                actData_r[i] <= 16'h0000;
            end
        end else if (fsRise && ackS2_r == reqTgl_r) begin
            reqTgl_r <= ~reqTgl_r;
            for (int i = 0; i < `TDMSSM_REG_COUNT; i++) begin
                actCfg_r[i] <= holdCfg_r[i];
            end
            for (int i = 0; i < NSRC; i++) begin
                actData_r[i] <= holdData_r[i];
            end
        end
    end

    // Frame state and bit position counted from the frame start.
    always_ff @(posedge serial_bit_clock or posedge linkRst) begin
        if (linkRst) begin
            linkState_r <= tdmssm_pkg::LNK_IDLE;
            bitPos_r    <= '0;
        end else if (fsRise) begin
            linkState_r <= tdmssm_pkg::LNK_SHIFT;
            bitPos_r    <= '0;
        end else begin
            case (linkState_r)
                tdmssm_pkg::LNK_SHIFT: begin
                    if (bitPos_r == '1) begin
                        linkState_r <= tdmssm_pkg::LNK_DONE;
                    end
                    bitPos_r <= bitPos_r + POS_W'(1);
                end
                default: begin
                    bitPos_r <= bitPos_r;
                end
            endcase
        end
    end

    // Pick the bit of the first enabled source whose slot and length cover this position.
    logic [5:0]       curSlot;
    logic [BIT_W-1:0] curBit;
    logic             bitHit;
    logic             bitVal;
    logic [4:0]       srcLen;
    logic [7:0]       srcCfg;
    assign curSlot = bitPos_r[POS_W-1:BIT_W];
    assign curBit  = bitPos_r[BIT_W-1:0];

    always_comb begin
        bitHit = 1'b0;
        bitVal = 1'b0;
        srcLen = 5'h00;
        srcCfg = 8'h00;
        for (int s = NSRC - 1; s >= 0; s--) begin
            // Current sense settings sit at index 2 and voltage sense at 1; the rest follow in order.
            srcCfg = actCfg_r[(s == 0) ? 2 : ((s == 1) ? 1 : s + 1)];
            if (s == 3) begin
                srcLen = srcCfg[`TDMSSM_VBAT_LEN_BIT] ? 5'h10 : 5'h08;
            end else if (s >= 4) begin
                srcLen = 5'h08;
            end else begin
                srcLen = 5'h10;
            end
            if (srcCfg[`TDMSSM_TX_EN_BIT] && srcCfg[`TDMSSM_SLOT_MSB:0] == curSlot &&
                {{(5 - BIT_W > 0 ? 5 - BIT_W : 0){1'b0}}, curBit} < srcLen) begin
                bitHit = 1'b1;
                bitVal = actData_r[s][4'(15 - curBit)];
            end
        end
    end

    // Output stage: data bits driven, other positions zero or released per the fill bit.
    always_ff @(posedge serial_bit_clock or posedge linkRst) begin
        if (linkRst) begin
            serialOutLine_r   <= 1'b0;
            serialOutLineEn_r <= 1'b0;
        end else if (linkState_r == tdmssm_pkg::LNK_SHIFT && !fsRise && bitHit) begin
            serialOutLine_r   <= bitVal;
            serialOutLineEn_r <= 1'b1;
        end else begin
            serialOutLine_r   <= 1'b0;
            serialOutLineEn_r <= !actCfg_r[0][`TDMSSM_FILL_BIT];
        end
    end
endmodule

// file: tdmssm_checker.sv
// Register port checks of the slot mapper.
`timescale 1ns/1ps
module tdmssm_checker (
    // Clock and reset.
    input wire logic       clk,
    input wire logic       sys_rst,
    // Register port.
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrEn,
    input wire logic       regRdEn,
    input wire logic [7:0] regRdData_r
);
    logic hit;
    // Offsets that hold a register.
    assign hit = (regAddr >= 8'h0E) && (regAddr <= 8'h15);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // Steps of a register access.
    sequence s_wr;
        regWrEn && hit;
    endsequence
    sequence s_rd;
        regRdEn && !regWrEn;
    endsequence
    sequence s_rdSame;
        regRdEn && !regWrEn && (regAddr == $past(regAddr));
    endsequence
    property p_wr_rd;
        s_wr ##1 s_rdSame |=> regRdData_r == $past(regWrData, 2);
    endproperty
    property p_two_wr;
        s_wr ##1 (regWrEn && hit && regAddr != $past(regAddr))
        ##1 (regRdEn && !regWrEn && regAddr == $past(regAddr, 2)) |=> regRdData_r == $past(regWrData, 3);
    endproperty
    property p_reread;
        s_rd ##1 s_rdSame |=> $stable(regRdData_r);
    endproperty
    property p_rw_same;
        s_rd ##1 (regRdEn && regWrEn && $stable(regAddr)) |=> $stable(regRdData_r);
    endproperty
    property p_hold;
        !regRdEn |=> $stable(regRdData_r);
    endproperty
    property p_unmapped;
        regRdEn && !hit |=> regRdData_r == 8'h00;
    endproperty
    property p_wr_unmapped;
        regWrEn && !hit ##1 s_rdSame |=> regRdData_r == 8'h00;
    endproperty
    property p_reset_exit;
        $fell(sys_rst) |-> regRdData_r == 8'h00;
    endproperty
    a_wr_rd: assert property (p_wr_rd) else $error("read after write lost data");
    a_two_wr: assert property (p_two_wr) else $error("second write disturbed first");
    a_reread: assert property (p_reread) else $error("repeated read changed");
    a_rw_same: assert property (p_rw_same) else $error("read with write not old value");
    a_hold: assert property (p_hold) else $error("read data moved without read");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_wr_unmapped: assert property (p_wr_unmapped) else $error("unmapped write stored");
    a_reset_exit: assert property (p_reset_exit) else $error("read data not clear at reset");
endmodule
bind tdmssm_top tdmssm_checker u_checker (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData_r(regRdData_r));

// file: tdmssm_host_model.sv
// Host audio processor model that clocks one frame and captures the line.
`timescale 1ns/1ps
module tdmssm_host_model (
    // Frame request.
    input  wire logic     startFrame,
    output logic          frameDone,
    // Link pins.
    output logic          serial_bit_clock,
    output logic          frameSync,
    input  wire logic     serialOutLine_r,
    input  wire logic     serialOutLineEn_r,
    // Frame as seen at the pin.
    output logic [1023:0] capData,
    output logic [1023:0] capEn
);
    logic lastLevel;
    // A released pin reads back the inverse of the last driven level.
    wire logic pinLevel = serialOutLineEn_r ? serialOutLine_r : ~lastLevel;
    // The bit clock runs only for eight cycles at start-up and within frames.
    initial begin
        serial_bit_clock = 1'b0;
        frameSync = 1'b0;
        frameDone = 1'b0;
        lastLevel = 1'b0;
        capData = '0;
        capEn = '0;
        repeat (8) begin
            #80 serial_bit_clock = 1'b1;
            #80 serial_bit_clock = 1'b0;
        end
        forever begin
            wait (startFrame);
            frameDone = 1'b0;
            for (int i = 0; i < 1030; i++) begin
                frameSync = (i < 32);
                #80 serial_bit_clock = 1'b1;
                #80 serial_bit_clock = 1'b0;
                // Position zero follows the third rising edge after sync is seen.
                if (i >= 3 && i < 1027) begin
                    capData[i-3] = pinLevel;
                    capEn[i-3] = serialOutLineEn_r;
                end
                if (serialOutLineEn_r) lastLevel = serialOutLine_r;
            end
            frameSync = 1'b0;
            frameDone = 1'b1;
            wait (!startFrame);
        end
    end
endmodule

// file: tdm_sense_slot_mapper_bench.sv
// Self-checking bench for the slot mapper and its limiter.
`timescale 1ns/1ps
module tdm_sense_slot_mapper_bench;
    logic          clk, sys_rst, regWrEn, regRdEn, overThreshold, startFrame, frameDone;
    logic [7:0]    regAddr, regWrData, regRdData_r, temperature;
    logic [15:0]   currentSenseData, voltageSenseData, decimatedData;
    logic [11:0]   supplyVoltage;
    logic          serial_bit_clock, frameSync, serialOutLine_r, serialOutLineEn_r;
    logic [1023:0] capData, capEn, expD, expE;
    int            num_errors, total_checks;
    // Design and host.
    tdmssm_top #(.ATK_BASE_CYCLES(2)) u_dut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData_r(regRdData_r),
        .currentSenseData(currentSenseData), .voltageSenseData(voltageSenseData),
        .decimatedData(decimatedData), .supplyVoltage(supplyVoltage), .temperature(temperature),
        .overThreshold(overThreshold), .serial_bit_clock(serial_bit_clock), .frameSync(frameSync),
        .serialOutLine_r(serialOutLine_r), .serialOutLineEn_r(serialOutLineEn_r));
    tdmssm_host_model u_host (.startFrame(startFrame), .frameDone(frameDone),
        .serial_bit_clock(serial_bit_clock), .frameSync(frameSync), .serialOutLine_r(serialOutLine_r),
        .serialOutLineEn_r(serialOutLineEn_r), .capData(capData), .capEn(capEn));
    // System clock of 50 MHz.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Counts and reports one comparison.
    task automatic check(input logic [1023:0] seen, input logic [1023:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    // One register port cycle, set at the falling edge.
    task automatic bus(input logic we, input logic re, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regWrEn = we;
        regRdEn = re;
        regAddr = a;
        regWrData = d;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        check(regRdData_r, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
        rd(a, d);
    endtask
    // Writes all registers in offset order.
    task automatic cfg(input logic [7:0] v [8]);
        for (int i = 0; i < 8; i++) wr(8'h0E + i[7:0], v[i]);
    endtask
    // Holds the level detector high on exactly n rising edges.
    task automatic pulse(input int n);
        @(negedge clk);
        overThreshold = 1'b1;
        repeat (n) @(negedge clk);
        overThreshold = 1'b0;
    endtask
    task automatic frame();
        int n;
        @(negedge clk);
        startFrame = 1'b1;
        n = 0;
        @(negedge clk);
        while (frameDone !== 1'b1 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        if (frameDone !== 1'b1) begin
            num_errors++;
        end
        startFrame = 1'b0;
    endtask
    // Marks one source's bits, most significant first, in its slot.
    task automatic place(input logic [5:0] slot, input logic [15:0] w, input int nb);
        for (int b = 0; b < nb; b++) begin
            expD[slot*16+b] = w[15-b];
            expE[slot*16+b] = 1'b1;
        end
    endtask
    // Settings take effect from the second frame start after the writes.
    task automatic run_check();
        frame();
        frame();
        check(capEn, expE);
        check(capData & expE, expD & expE);
    endtask
    task automatic test_registers();
        logic [7:0] rstVal [8];
        rstVal = '{8'h13, 8'h02, 8'h00, 8'h04, 8'h06, 8'h07, 8'h08, 8'h14};
        for (int i = 0; i < 8; i++) rd(8'h0E + i[7:0], rstVal[i]);
        bus(1'b1, 1'b0, 8'h16, 8'hFF);
        rd(8'h16, 8'h00);
        rd(8'h0D, 8'h00);
        bus(1'b0, 1'b1, 8'h10, 8'h00);
        bus(1'b1, 1'b1, 8'h10, 8'h3F);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        check(regRdData_r, 8'h00);
        rd(8'h10, 8'h3F);
        bus(1'b1, 1'b0, 8'h0F, 8'h15);
        bus(1'b1, 1'b0, 8'h10, 8'h2A);
        rd(8'h0F, 8'h15);
        rd(8'h10, 8'h2A);
    endtask
    task automatic test_limiter();
        wr(8'h14, 8'h48);
        wr(8'h0E, 8'h03);
        wr(8'h15, 8'h33);
        pulse(4);
        pulse(8);
        wr(8'h15, 8'h0F);
        repeat (300) @(negedge clk);
        pulse(256);
        expE = '1;
        expD = '0;
        place(6'd8, 16'h1900, 8);
        run_check();
    endtask
    task automatic test_map_a();
        cfg('{8'h03, 8'h42, 8'h40, 8'h44, 8'hC6, 8'h47, 8'h48, 8'h0F});
        expE = '1;
        expD = '0;
        place(6'd0, currentSenseData, 16);
        place(6'd2, voltageSenseData, 16);
        place(6'd4, decimatedData, 16);
        place(6'd6, {supplyVoltage, 4'h0}, 16);
        place(6'd7, {temperature, 8'h00}, 8);
        place(6'd8, 16'h1900, 8);
        run_check();
    endtask
    task automatic test_map_b();
        cfg('{8'h13, 8'h02, 8'h41, 8'h4A, 8'h4C, 8'h54, 8'h7F, 8'h14});
        expE = '0;
        expD = '0;
        place(6'd1, currentSenseData, 16);
        place(6'd10, decimatedData, 16);
        place(6'd12, {supplyVoltage[11:4], 8'h00}, 8);
        place(6'd20, {temperature, 8'h00}, 8);
        place(6'd63, 16'h0000, 8);
        run_check();
    endtask
    task automatic stop_test();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Cuts a hang short after about 100000 clock cycles.
    initial begin
        #2000000;
        num_errors++;
        stop_test();
    end
    // Main sequence.
    initial begin
        {sys_rst, regWrEn, regRdEn, overThreshold, startFrame} = 5'h10;
        {regAddr, regWrData, num_errors, total_checks} = '0;
        currentSenseData = 16'hA5C3;
        voltageSenseData = 16'h3C5A;
        decimatedData = 16'h81F0;
        supplyVoltage = 12'hB7D;
        temperature = 8'h9E;
        repeat (6) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        // The link leaves reset on the idle bit clocks and must leave the line released.
        repeat (70) @(negedge clk);
        check(serialOutLineEn_r, 1'b0);
        frame();
        test_registers();
        test_limiter();
        test_map_a();
        test_map_b();
        stop_test();
    end
endmodule
